/* include/mac_pkg.sv */
// Constants and types shared by the memory access checker files
package mac_pkg;

    // ----------------------------------------------------------------
    // Table geometry
    // ----------------------------------------------------------------
    localparam int unsigned DATA_ENTRIES = 4;
    localparam int unsigned CODE_ENTRIES = 2;
    localparam int unsigned CFG_WORDS = 28;

    // ----------------------------------------------------------------
    // Register word indices (byte offset is four times the index)
    // ----------------------------------------------------------------
    localparam int unsigned IDX_DATA_BOUND = 0;
    localparam int unsigned IDX_CODE_BOUND = 16;
    localparam int unsigned IDX_DATA_MODE = 24;
    localparam int unsigned IDX_CODE_MODE = 26;
    localparam logic [9:0] IDX_CONTROL = 10'h01c;
    localparam logic [9:0] IDX_STATUS = 10'h01d;
    localparam logic [9:0] IDX_TRAP_ADDR = 10'h01e;

    // ----------------------------------------------------------------
    // Field positions, masks and reset values
    // ----------------------------------------------------------------
    localparam int unsigned MODE_FIELD_W = 8;
    localparam int unsigned MODE_LOAD_BIT = 6;
    localparam int unsigned MODE_STORE_BIT = 7;
    localparam int unsigned MODE_FETCH_BIT = 7;
    localparam logic [31:0] CODE_MODE_MASK = 32'h0000_a9a9;
    localparam logic [31:0] FULL_MASK = 32'hffff_ffff;
    localparam int unsigned CTRL_PROT_EN_BIT = 0;
    localparam int unsigned STAT_SEEN_BIT = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Privilege levels and address segments
    // ----------------------------------------------------------------
    localparam logic [1:0] PRV_USER0 = 2'h0;
    localparam logic [1:0] PRV_USER1 = 2'h1;
    localparam logic [1:0] PRV_SUPER = 2'h2;
    localparam logic [3:0] SEG_PERIPH_A = 4'he;
    localparam logic [3:0] SEG_PERIPH_B = 4'hf;
    localparam logic [3:0] SEG_LOCAL_A = 4'hc;
    localparam logic [3:0] SEG_LOCAL_B = 4'hd;
    localparam logic [27:0] LOCAL_IMPL_BYTES = 28'h001_0000;

    // ----------------------------------------------------------------
    // Access kinds, sizes and trap causes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {KIND_LOAD, KIND_STORE, KIND_FETCH, KIND_NONE} mac_kind_type;
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_DWORD} mac_size_type;
    typedef enum logic [1:0] {CAUSE_NONE, CAUSE_PROTECT, CAUSE_BUS, CAUSE_ALIGN} mac_cause_type;

endpackage : mac_pkg

/* include/mac_table_if.sv */
// Range table bundle between the checker and its range matcher
`timescale 1ns/10ps
interface mac_table_if;
    logic [31:0] addr;                          // First byte address
    logic [31:0] lower [mac_pkg::DATA_ENTRIES]; // Inclusive bounds
    logic [31:0] upper [mac_pkg::DATA_ENTRIES]; // Exclusive bounds
    logic [mac_pkg::DATA_ENTRIES-1:0] grant;    // Mode bit for the kind
    wire [mac_pkg::DATA_ENTRIES-1:0] hit;       // Per entry match
    wire permit;                                // Any granting match

    modport owner (output addr, lower, upper, grant, input hit, permit);
    modport matcher (input addr, lower, upper, grant, output hit, permit);
endinterface : mac_table_if

/* src/mac_checker.sv */
// Memory access checker: range tables, privilege checks and traps
//
// Operation
// - Two register sets, chosen by protection_set_select input
// - Overlapping or nested entries judged independently
// - Enabled protection judges aligned non-peripheral accesses, before existence
// - Privilege 0 user, 1 elevated, 2 supervisor
// - Data uses data table, fetch code table
// - Data modes read/write, code modes execute
// - Program-space reads need covering data entry
// - Top segments 1110 and 1111 skip tables
// - Peripheral segments refused at privilege 0
// - Supervisor line marks privilege 2 on bus
// - Protection off permits all non-peripheral accesses
// - Enabled: some hit must grant kind
// - Decision ignores whether memory exists
// - Refused access raises protection trap
// - Missing local memory raises bus error
// - Misalignment raises alignment trap, not protection
// - Only first byte address is compared
// - Fetch checks program counter start only
// - Match is lower <= address < upper
// - Supervisor accesses still range checked
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module mac_checker
(
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side request
    input wire logic acc_valid,
    input wire logic [1:0] acc_kind,
    input wire logic [1:0] acc_size,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    input wire logic [1:0] io_privilege,
    input wire logic protection_set_select,
    // Memory and peripheral bus side
    output logic mem_valid,
    output logic mem_write,
    output logic mem_fetch,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic mem_supervisor,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    // Read data back to the core
    output logic core_rvalid,
    output logic [31:0] core_rdata,
    // Trap report
    output logic trap_valid,
    output logic [1:0] trap_cause,
    output logic [31:0] trap_addr
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [31:0] cfg [mac_pkg::CFG_WORDS]; // Bounds and mode words
    logic prot_enable;                     // System control word bit
    logic [1:0] stat_cause;                // Last trap cause
    logic stat_seen;                       // Sticky trap flag
    logic [31:0] stat_addr;                // Last trapped address

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire [9:0] widx = paddr[11:2];
    wire apb_access = psel && penable;
    wire apb_done = apb_access && pready;
    wire apb_wr = apb_done && pwrite;
    wire is_cfg = widx < 10'(mac_pkg::CFG_WORDS);
    wire is_ctrl = widx == mac_pkg::IDX_CONTROL;
    wire is_stat = widx == mac_pkg::IDX_STATUS;
    wire is_taddr = widx == mac_pkg::IDX_TRAP_ADDR;
    wire mapped = is_cfg || is_ctrl || is_stat || is_taddr;
    wire [31:0] byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                             {8{pstrb[1]}}, {8{pstrb[0]}}};
    // Status clear: writing one to the sticky bit
    wire stat_clear = apb_wr && is_stat && pstrb[1]
        && pwdata[mac_pkg::STAT_SEEN_BIT];
    wire [31:0] rd_cfg = is_cfg ? cfg[widx[4:0]] : 32'h0000_0000;
    wire [31:0] rd_mux = is_cfg ? rd_cfg
        : is_ctrl ? {31'h0000_0000, prot_enable}
        : is_stat ? {23'h00_0000, stat_seen, 6'h00, stat_cause}
        : is_taddr ? stat_addr
        : 32'h0000_0000;
    // One wait state: ready rises in the second access cycle
    wire next_pready = apb_access && !pready;

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // Unmapped offsets answer with an error and zero data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pready && !mapped;
            prdata <= next_pready ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Range and mode words, one writer per word
    // ----------------------------------------------------------------
    // Code mode words keep only their defined bits; the rest read zero
    genvar g;
    generate
        for (g = 0; g < mac_pkg::CFG_WORDS; g++)
        begin : g_cfg
            localparam logic [31:0] WMASK = (g >= mac_pkg::IDX_CODE_MODE)
                ? mac_pkg::CODE_MODE_MASK : mac_pkg::FULL_MASK;
            wire sel = apb_wr && is_cfg && (widx[4:0] == 5'(g));
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cfg[g] <= mac_pkg::CFG_RESET;
                else if (sel)
                    cfg[g] <= (cfg[g] & ~(byte_mask & WMASK))
                        | (pwdata & byte_mask & WMASK);
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // System control word
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prot_enable <= 1'b0;
        else if (apb_wr && is_ctrl && pstrb[0])
            prot_enable <= pwdata[mac_pkg::CTRL_PROT_EN_BIT];
    end

    // ----------------------------------------------------------------
    // Access classification
    // ----------------------------------------------------------------
    wire is_fetch = acc_kind == mac_pkg::KIND_FETCH;
    wire is_store = acc_kind == mac_pkg::KIND_STORE;
    wire is_load = acc_kind == mac_pkg::KIND_LOAD;
    wire kind_ok = is_fetch || is_store || is_load;
    wire [3:0] seg = acc_addr[31:28];
    wire is_periph = (seg == mac_pkg::SEG_PERIPH_A)
        || (seg == mac_pkg::SEG_PERIPH_B);
    wire is_local = (seg == mac_pkg::SEG_LOCAL_A)
        || (seg == mac_pkg::SEG_LOCAL_B);
    // Level 3 is undefined and is handled like the lowest level
    wire prv_low = (io_privilege != mac_pkg::PRV_USER1)
        && (io_privilege != mac_pkg::PRV_SUPER);
    // Anything wider than a byte, and every fetch, is half-word aligned
    wire misaligned = acc_addr[0]
        && (is_fetch || (acc_size != mac_pkg::SIZE_BYTE));

    // ----------------------------------------------------------------
    // Range table feed, selected set only
    // ----------------------------------------------------------------
    // Only the first byte address is compared, whatever the size
    mac_table_if tbl ();
    assign tbl.addr = acc_addr;

    wire [31:0] dmode = protection_set_select
        ? cfg[mac_pkg::IDX_DATA_MODE + 1]
        : cfg[mac_pkg::IDX_DATA_MODE];
    wire [31:0] cmode = protection_set_select
        ? cfg[mac_pkg::IDX_CODE_MODE + 1]
        : cfg[mac_pkg::IDX_CODE_MODE];

    genvar e;
    generate
        for (e = 0; e < mac_pkg::DATA_ENTRIES; e++)
        begin : g_feed
            localparam int unsigned D0 = mac_pkg::IDX_DATA_BOUND + 2 * e;
            localparam int unsigned D1 = D0 + 2 * mac_pkg::DATA_ENTRIES;
            localparam int unsigned C0 = mac_pkg::IDX_CODE_BOUND
                + 2 * (e % mac_pkg::CODE_ENTRIES);
            localparam int unsigned C1 = C0 + 2 * mac_pkg::CODE_ENTRIES;
            localparam bit HAS_CODE = e < mac_pkg::CODE_ENTRIES;
            localparam int unsigned FB = mac_pkg::MODE_FIELD_W * e;
            wire [31:0] dlo = protection_set_select ? cfg[D1] : cfg[D0];
            wire [31:0] dhi = protection_set_select ? cfg[D1 + 1] : cfg[D0 + 1];
            wire [31:0] clo = protection_set_select ? cfg[C1] : cfg[C0];
            wire [31:0] chi = protection_set_select ? cfg[C1 + 1] : cfg[C0 + 1];
            // Fetches see only the code table, loads and stores the data
            // table; missing code entries get an empty range
            assign tbl.lower[e] = is_fetch
                ? (HAS_CODE ? clo : 32'h0000_0000) : dlo;
            assign tbl.upper[e] = is_fetch
                ? (HAS_CODE ? chi : 32'h0000_0000) : dhi;
            // Data modes carry read and write, code modes only execute
            assign tbl.grant[e] = is_fetch
                ? (HAS_CODE && cmode[FB + mac_pkg::MODE_FETCH_BIT])
                : is_store ? dmode[FB + mac_pkg::MODE_STORE_BIT]
                : dmode[FB + mac_pkg::MODE_LOAD_BIT];
        end
    endgenerate

    mac_range_match u_match
    (
        .tbl (tbl)
    );

    // ----------------------------------------------------------------
    // Verdict, same cycle as the request
    // ----------------------------------------------------------------
    // Supervisor gets no bypass: it goes through the table too
    wire range_ok = !prot_enable || tbl.permit;
    wire periph_ok = !prv_low;
    wire permitted = is_periph ? periph_ok : range_ok;
    // Existence is only looked at after permission is granted
    wire unimpl = is_local
        && (acc_addr[27:0] >= mac_pkg::LOCAL_IMPL_BYTES);
    wire [1:0] next_cause = misaligned ? mac_pkg::CAUSE_ALIGN
        : !permitted ? mac_pkg::CAUSE_PROTECT
        : unimpl ? mac_pkg::CAUSE_BUS
        : mac_pkg::CAUSE_NONE;
    wire next_trap = acc_valid && kind_ok
        && (next_cause != mac_pkg::CAUSE_NONE);
    wire next_issue = acc_valid && kind_ok
        && (next_cause == mac_pkg::CAUSE_NONE);

    // ----------------------------------------------------------------
    // Bus request and trap outputs
    // ----------------------------------------------------------------
    // Registering the verdict costs one cycle but keeps the bus
    // free of comparator glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_valid <= 1'b0;
            mem_write <= 1'b0;
            mem_fetch <= 1'b0;
            mem_size <= 2'h0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            trap_valid <= 1'b0;
            trap_cause <= 2'h0;
            trap_addr <= 32'h0000_0000;
        end
        else
        begin
            mem_valid <= next_issue;
            mem_write <= next_issue && is_store;
            mem_fetch <= next_issue && is_fetch;
            mem_size <= next_issue ? acc_size : 2'h0;
            mem_addr <= next_issue ? acc_addr : 32'h0000_0000;
            // Trapped stores never put their data on the bus
            mem_wdata <= (next_issue && is_store)
                ? acc_wdata : 32'h0000_0000;
            trap_valid <= next_trap;
            trap_cause <= next_trap ? next_cause : mac_pkg::CAUSE_NONE;
            trap_addr <= next_trap ? acc_addr : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Supervisor line and read return
    // ----------------------------------------------------------------
    // Only issued reads are answered, so a trapped load gets no data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_supervisor <= 1'b0;
            core_rvalid <= 1'b0;
            core_rdata <= 32'h0000_0000;
        end
        else
        begin
            mem_supervisor <= io_privilege == mac_pkg::PRV_SUPER;
            core_rvalid <= mem_rvalid;
            core_rdata <= mem_rvalid ? mem_rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Trap status register
    // ----------------------------------------------------------------
    // A trap in the clearing cycle wins, so no event is lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_seen <= 1'b0;
            stat_cause <= 2'h0;
            stat_addr <= 32'h0000_0000;
        end
        else
        begin
            stat_seen <= next_trap || (stat_seen && !stat_clear);
            if (next_trap)
            begin
                stat_cause <= next_cause;
                stat_addr <= acc_addr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_apb_wait;
        psel && penable && !pready;
    endsequence

    sequence s_apb_answer;
        pready ##1 !pready;
    endsequence

    sequence s_plain_req;
        acc_valid && kind_ok && !misaligned;
    endsequence

    a_apb_one_wait: assert property (s_apb_wait |=> s_apb_answer)
        else $error("APB answer not after exactly one wait state");

    a_align_first: assert property (
        acc_valid && kind_ok && misaligned
        |=> trap_valid && trap_cause == mac_pkg::CAUSE_ALIGN && !mem_valid)
        else $error("Misaligned access did not raise alignment trap");

    a_user0_periph: assert property (
        s_plain_req and (is_periph && prv_low)
        |=> trap_cause == mac_pkg::CAUSE_PROTECT && !mem_valid)
        else $error("Lowest level reached a peripheral segment");

    a_user1_periph: assert property (
        s_plain_req and (is_periph && !prv_low)
        |=> mem_valid && !trap_valid)
        else $error("Elevated level refused a peripheral segment");

    a_super_line: assert property (
        mem_supervisor == ($past(io_privilege) == mac_pkg::PRV_SUPER))
        else $error("Supervisor line does not follow privilege");

    a_open_when_off: assert property (
        s_plain_req and (!prot_enable && !is_periph && !is_local)
        |=> mem_valid && mem_addr == $past(acc_addr))
        else $error("Disabled protection refused an access");

    a_deny_no_hit: assert property (
        s_plain_req and (prot_enable && !is_periph && tbl.hit == '0)
        |=> trap_cause == mac_pkg::CAUSE_PROTECT && !mem_valid)
        else $error("Access outside every range was let through");

    a_bus_error: assert property (
        s_plain_req and (!prot_enable && unimpl)
        |=> trap_cause == mac_pkg::CAUSE_BUS)
        else $error("Missing local memory gave no bus error");

    a_verdict_next: assert property (
        acc_valid && kind_ok |=> mem_valid != trap_valid)
        else $error("Access got no single verdict next cycle");

    a_no_wdata: assert property (
        !mem_write |-> mem_wdata == 32'h0000_0000)
        else $error("Write data leaked without an issued store");

    a_sticky_set: assert property (
        next_trap |=> (stat_seen && stat_clear) or stat_seen [*2])
        else $error("Trap flag not held after a trap");

endmodule : mac_checker

/* src/mac_range_match.sv */
// Parallel range comparators of one protection table
`timescale 1ns/10ps
module mac_range_match
(
    mac_table_if.matcher tbl
);

    // ----------------------------------------------------------------
    // One comparator pair per entry
    // ----------------------------------------------------------------
    // Every entry is judged on its own, so nested ranges simply add up
    genvar i;
    generate
        for (i = 0; i < mac_pkg::DATA_ENTRIES; i++)
        begin : g_entry
            assign tbl.hit[i] = (tbl.addr >= tbl.lower[i])
                && (tbl.addr < tbl.upper[i]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Verdict
    // ----------------------------------------------------------------
    // A single matching entry that grants the kind is enough
    assign tbl.permit = |(tbl.hit & tbl.grant);

endmodule : mac_range_match

/* verification/mac_checker_tb.sv */
// Self-checking testbench of the memory access checker
`timescale 1ns/10ps
module mac_checker_tb;
    // ------------------------------------------------------------
    // Signals, counters and short names for kinds and causes
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, acc_addr, acc_wdata, mem_addr, mem_wdata, mem_rdata;
    logic acc_valid, protection_set_select, mem_valid, mem_write, mem_fetch, mem_supervisor;
    logic [1:0] acc_kind, acc_size, io_privilege, mem_size, trap_cause;
    logic mem_rvalid, core_rvalid, trap_valid;
    logic [31:0] core_rdata, trap_addr;
    logic [31:0] lfsr = 32'h5bd4; // Fixed seed keeps every run the same
    int miscompares = 0; // Mismatches seen
    int checked = 0; // Comparisons made
    localparam logic [1:0] LD = mac_pkg::KIND_LOAD;
    localparam logic [1:0] ST = mac_pkg::KIND_STORE;
    localparam logic [1:0] FE = mac_pkg::KIND_FETCH;
    localparam logic [1:0] PR = mac_pkg::CAUSE_PROTECT;
    localparam logic [1:0] AL = mac_pkg::CAUSE_ALIGN;

    mac_checker i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .acc_valid, .acc_kind, .acc_size, .acc_addr, .acc_wdata,
        .io_privilege, .protection_set_select, .mem_valid, .mem_write, .mem_fetch, .mem_size,
        .mem_addr, .mem_wdata, .mem_supervisor, .mem_rvalid, .mem_rdata, .core_rvalid,
        .core_rdata, .trap_valid, .trap_cause, .trap_addr);
    mac_mem_model i_mem (.pclk, .presetn, .mem_valid, .mem_write, .mem_addr, .mem_rvalid,
        .mem_rdata);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : step

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer; ready, data and error are taken at the edge that ends it
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One core access and its verdict in the following cycle
    task automatic acc(logic [1:0] k, logic [1:0] s, logic [31:0] a, logic [1:0] p,
                       logic st, logic [1:0] exp);
        logic [31:0] w;
        w = lfsr;
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_kind <= k;
        acc_size <= s;
        acc_addr <= a;
        io_privilege <= p;
        protection_set_select <= st;
        acc_wdata <= w;
        @(posedge pclk);
        acc_valid <= 1'b0;
        #1;
        check("trap_cause", {30'h0, trap_cause}, {30'h0, exp});
        check("mem_valid", {31'h0, mem_valid}, {31'h0, exp == 2'h0});
        check("mem_addr", mem_addr, (exp == 2'h0) ? a : 32'h0);
        check("trap_addr", trap_addr, (exp != 2'h0) ? a : 32'h0);
        check("mem_wdata", mem_wdata, (exp == 2'h0 && k == ST) ? w : 32'h0);
        check("mem_supervisor", {31'h0, mem_supervisor}, {31'h0, p == 2'h2});
        check("trap_valid", {31'h0, trap_valid}, {31'h0, exp != 2'h0});
        check("mem_write", {31'h0, mem_write}, {31'h0, exp == 2'h0 && k == ST});
        check("mem_fetch", {31'h0, mem_fetch}, {31'h0, exp == 2'h0 && k == FE});
        check("mem_size", {30'h0, mem_size}, (exp == 2'h0) ? {30'h0, s} : 32'h0);
    endtask : acc

    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // A few hundred cycles are expected; far beyond that means a hang
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, acc_valid, protection_set_select} = '0;
        {paddr, pwdata, acc_addr, acc_wdata, acc_kind, acc_size, io_privilege} = '0;
        pstrb = 4'hf;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h070, 32'h0);
        check("control", rd, 32'h0);
        apb(1'b0, 12'h07c, 32'h0);
        check("pslverr", {31'h0, err}, 32'h1);
        acc(LD, 2'h2, 32'h0000_1000, 2'h0, 1'b0, 2'h0);
        acc(LD, 2'h2, 32'hc001_0000, 2'h2, 1'b0, mac_pkg::CAUSE_BUS);
        acc(LD, 2'h1, 32'h0000_1001, 2'h2, 1'b0, AL);
        acc(ST, 2'h0, 32'he000_0001, 2'h0, 1'b0, PR);
        acc(LD, 2'h2, 32'hf000_0000, 2'h1, 1'b0, 2'h0);
        // Set 0: load range with a nested store range, one fetch range
        apb(1'b1, 12'h000, 32'h0000_1000);
        apb(1'b1, 12'h004, 32'h0000_2000);
        apb(1'b1, 12'h008, 32'h0000_1800);
        apb(1'b1, 12'h00c, 32'h0000_1900);
        apb(1'b1, 12'h060, 32'h0000_8040);
        apb(1'b1, 12'h040, 32'h0000_3000);
        apb(1'b1, 12'h044, 32'h0000_3100);
        apb(1'b1, 12'h068, 32'h0000_ff80);
        apb(1'b0, 12'h068, 32'h0);
        check("code_mode", rd, 32'h0000_a980);
        apb(1'b1, 12'h070, 32'h1);
        acc(ST, 2'h2, 32'h0000_1800, 2'h0, 1'b0, 2'h0);
        acc(ST, 2'h3, 32'h0000_18fe, 2'h0, 1'b0, 2'h0);
        acc(ST, 2'h2, 32'h0000_1900, 2'h0, 1'b0, PR);
        acc(ST, 2'h2, 32'h0000_1000, 2'h1, 1'b0, PR);
        acc(LD, 2'h2, 32'h0000_1000, 2'h0, 1'b0, 2'h0);
        acc(LD, 2'h2, 32'h0000_2000, 2'h0, 1'b0, PR);
        acc(LD, 2'h2, 32'h0000_1000, 2'h0, 1'b1, PR);
        acc(LD, 2'h2, 32'h0000_1000, 2'h2, 1'b1, PR);
        acc(FE, 2'h1, 32'h0000_30fe, 2'h0, 1'b0, 2'h0);
        acc(FE, 2'h1, 32'h0000_3100, 2'h0, 1'b0, PR);
        acc(FE, 2'h1, 32'h0000_1000, 2'h0, 1'b0, PR);
        acc(LD, 2'h2, 32'h0000_3000, 2'h0, 1'b0, PR);
        acc(LD, 2'h2, 32'he000_0000, 2'h1, 1'b1, 2'h0);
        acc(LD, 2'h2, 32'hc000_0000, 2'h0, 1'b0, PR);
        acc(LD, 2'h1, 32'h0000_0001, 2'h0, 1'b0, AL);
        apb(1'b0, 12'h074, 32'h0);
        check("status", rd, 32'h0000_0103);
        apb(1'b1, 12'h074, 32'h0000_0100);
        apb(1'b0, 12'h074, 32'h0);
        check("status_clear", rd, 32'h0000_0003);
        apb(1'b1, 12'h070, 32'h0);
        // Random aligned loads with protection off, data returned to the core
        repeat (40)
        begin
            lfsr = step(lfsr);
            acc(LD, 2'h2, {2'h0, lfsr[29:2], 2'h0}, (lfsr[31:30] == 2'h3) ? 2'h2 : lfsr[31:30],
                lfsr[5], 2'h0);
            repeat (2) @(posedge pclk);
            #1;
            check("core_rdata", core_rdata, ~{2'h0, lfsr[29:2], 2'h0});
            check("core_rvalid", {31'h0, core_rvalid}, 32'h1);
        end
        tally_and_finish();
    end
endmodule : mac_checker_tb

/* verification/mac_mem_model.sv */
// Memory side model that answers loads issued by the memory access checker
`timescale 1ns/10ps
module mac_mem_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_valid,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    // ------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------
    // Loads answer one cycle later with the inverted address
    // Idle data keeps moving, so a stale value can never pass as a match
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0000_0000;
        end
        else
        begin
            mem_rvalid <= mem_valid && !mem_write;
            mem_rdata <= (mem_valid && !mem_write) ? ~mem_addr : mem_rdata + 32'h0101_0101;
        end
    end
endmodule : mac_mem_model
